// file: common/ssa_pkg.sv
// Constants for the switch status and analog select register block.
// Assumes a 200 MHz system clock and a 32-bit serial frame from the host.
package ssa_pkg;

  // ********************************
  // Frame layout
  // ********************************
  localparam int FRAME_W   = 32;
  localparam int ADDR_MSB  = 31;
  localparam int ADDR_LSB  = 25;
  localparam int RW_BIT    = 24;
  localparam int FAULT_BIT = 23;
  localparam int INTF_BIT  = 22;
  localparam int CNT_W     = 6;
  localparam logic [CNT_W-1:0] BIT_LAST = 6'h1f;
  localparam logic [CNT_W-1:0] BIT_DONE = 6'h20;

  // ********************************
  // Register addresses and fields
  // ********************************
  localparam logic [6:0] ADDR_ANALOG_MUX_OUTPUT   = 7'h1d;
  localparam logic [6:0] ADDR_STATUS = 7'h1f;
  localparam logic [6:0] ADDR_FAULT  = 7'h21;
  localparam int SEL_W    = 6;
  localparam int CUR_BIT  = 6;
  localparam int ANALOG_MUX_OUTPUT_W   = 7;
  localparam logic [ANALOG_MUX_OUTPUT_W-1:0] ANALOG_MUX_OUTPUT_RST = 7'h00;
  localparam logic [SEL_W-1:0]  CH_NONE  = 6'h00;
  localparam logic [SEL_W-1:0]  CH_TEMP  = 6'h17;
  localparam logic [SEL_W-1:0]  CH_BATT  = 6'h18;

  // ********************************
  // Switch and fault sources
  // ********************************
  localparam int SG_N  = 14;
  localparam int SP_N  = 8;
  localparam int SW_N  = 22;
  localparam int FLT_N = 7;
  localparam int FLG_W = 8;
  localparam logic [FLG_W-1:0] FLG_RST = 8'h01;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_MHZ         = 200;
  localparam int INT_RELEASE_US  = 1000;
  localparam int INT_RELEASE_CYC = INT_RELEASE_US * CLK_MHZ;
  localparam int REL_W           = 18;

  typedef enum logic [1:0] {
    RPL_PLAIN,
    RPL_STATUS,
    RPL_ANALOG_MUX_OUTPUT,
    RPL_FAULT
  } ssa_reply_e;

endpackage

// file: src/ssa_sync.sv
// Two-stage synchroniser for a vector of levels.
// Assumes each bit is a level that holds for several destination clocks.
`timescale 1ns/1ps
module ssa_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;

endmodule

// file: src/ssa_regs.sv
// Analog select register and switch status readout behind a serial link.
// Assumes the host is the serial master: it makes the link clock and
// keeps chip select high for a few system clocks between frames.
`timescale 1ns/1ps

// How it works
// [RQ1] Analog select register at address 0x1d, read and written by frames.
// [RQ2] Six-bit channel code: none, ground 0-13, programmable 0-7, temp, battery.
// [RQ3] The selected input reads zero in the next status reply.
// [RQ4] Bit 6 picks high impedance (reset) or wetting current on selection.
// [RQ5] Channel select resets to none; host may rewrite it any time.
// [RQ6] Status register 0x1f is read only; data come in the next reply.
// [RQ7] Switch bit is one when closed, zero when open.
// [RQ8] Reply: fault bit 23, interrupt bit 22, programmable 21-14, ground 13-0.
// [RQ9] Fault bit is the OR of all fault and wetting fault flags.
// [RQ10] After power-on both fault bit and interrupt flag read one.
// [RQ11] Fault bit holds until the fault register reply; that clears flags.
// [RQ12] Fault and interrupt bits ride bits 23 and 22 of every reply, except the fault reply, which sends zero at bit 23.
// [RQ13] A frame starts at chip select fall and runs 32 link clocks.
// [RQ14] Interrupt pin releases 1.0 ms after chip select falls if no fault stands, then re-arms.
// [RQ15] Interrupt flag sets on any switch change or new fault.
// [RQ16] A reply carrying the flag clears it; a lasting fault does not re-set.
// [RQ17] Fault register read at 0x21; flags come back in the next reply.
// [RQ18] Frame: address 31-25, write bit 24 high for write, data 23-0.
module ssa_regs
  import ssa_pkg::*;
#(
  parameter int unsigned INT_REL_CYC = INT_RELEASE_CYC
) (
  // System clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  // Serial link
  input  wire logic             sclk_in,
  input  wire logic             cs_n_in,
  input  wire logic             mosi_in,
  output logic                  miso_out,
  // Switch and fault sources
  input  wire logic [SG_N-1:0]  ground_switch_input_in,
  input  wire logic [SP_N-1:0]  programmable_switch_input_in,
  input  wire logic [FLT_N-1:0] fault_cond_in,
  // Analog mux control and interrupt
  output logic [SEL_W-1:0]      analog_channel_sel_out,
  output logic                  analog_source_current_sel_out,
  output logic                  int_n_out
);

  localparam logic [REL_W-1:0] REL_LAST = REL_W'(INT_REL_CYC - 1);
  localparam int SYN_W = SW_N + FLT_N + 2;

  // ********************************
  // Link domain
  // ********************************
  logic [CNT_W-1:0]   bit_cnt_ff;
  logic [FRAME_W-1:0] rx_shift_ff;
  logic [FRAME_W-1:0] tx_word_ff;
  logic [FRAME_W-1:0] frame_ff;
  logic               done_tgl_ff;
  logic               miso_ff;
  logic [FRAME_W-1:0] reply_ff;

  wire [CNT_W-1:0]   nxt_bit_cnt = (bit_cnt_ff == BIT_DONE) ? bit_cnt_ff
                                   : bit_cnt_ff + 6'h01;
  wire [FRAME_W-1:0] nxt_rx      = {rx_shift_ff[FRAME_W-2:0], mosi_in};
  wire               frame_end   = (bit_cnt_ff == BIT_LAST);
  wire [4:0]         tx_idx      = 5'h1f - bit_cnt_ff[4:0];
  wire               tx_live     = (bit_cnt_ff != 6'h00)
                                   && (bit_cnt_ff != BIT_DONE);
  wire               tx_bit      = tx_live & tx_word_ff[tx_idx];

  // Chip select high holds the shifter idle; clocks past 32 are ignored
  always_ff @(posedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      bit_cnt_ff  <= 6'h00;
      rx_shift_ff <= 32'h0000_0000;
      tx_word_ff  <= 32'h0000_0000;
    end
    else
    begin
      bit_cnt_ff  <= nxt_bit_cnt;                              // [RQ13]
      rx_shift_ff <= nxt_rx;                                   // [RQ18]
      if (bit_cnt_ff == 6'h00)
        tx_word_ff <= reply_ff;
    end
  end

  // Completed frame stays until the next frame ends, long after the toggle
  always_ff @(posedge sclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      frame_ff    <= 32'h0000_0000;
      done_tgl_ff <= 1'b0;
    end
    else if (!cs_n_in && frame_end)
    begin
      frame_ff    <= nxt_rx;                                   // [RQ13]
      done_tgl_ff <= ~done_tgl_ff;
    end
  end

  // Bit 31 is always zero, so the idle level already serves as first bit
  always_ff @(negedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
      miso_ff <= 1'b0;
    else
      miso_ff <= tx_bit;
  end

  assign miso_out = miso_ff;

  // ********************************
  // Crossings into system domain
  // ********************************
  logic [SW_N-1:0]  sw_sync;
  logic [FLT_N-1:0] flt_sync;
  logic             cs_sync;
  logic             done_sync;
  logic [SYN_W-1:0] sync_q;

  // One bank for all levels; every bit is its own two-flop chain
  ssa_sync #(.W(SYN_W)) u_sync (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({done_tgl_ff, cs_n_in, fault_cond_in,
                programmable_switch_input_in, ground_switch_input_in}),
    .q_out    (sync_q)
  );
  assign {done_sync, cs_sync, flt_sync, sw_sync} = sync_q;       // [RQ7]

  // ********************************
  // System domain state
  // ********************************
  logic [SW_N-1:0]   sw_prev_ff;
  logic [FLT_N-1:0]  flt_prev_ff;
  logic              cs_seen_ff;
  logic              done_seen_ff;
  logic [ANALOG_MUX_OUTPUT_W-1:0] analog_mux_output_ff;
  ssa_reply_e        reply_kind_ff;
  logic [FLG_W-1:0]  flags_ff;
  logic              intflg_ff;
  logic              int_pend_ff;
  logic              int_n_ff;
  logic              rel_run_ff;
  logic [REL_W-1:0]  rel_cnt_ff;
  logic [SW_N-1:0]   sel_mask;
  ssa_reply_e        nxt_reply_kind;

  // ********************************
  // Frame decode
  // ********************************
  wire [6:0]  fr_addr    = frame_ff[ADDR_MSB:ADDR_LSB];
  wire        fr_wr      = frame_ff[RW_BIT];
  wire [23:0] fr_data    = frame_ff[23:0];
  wire        frame_done = done_sync ^ done_seen_ff;
  wire        analog_mux_output_wr    = frame_done && fr_wr
                           && (fr_addr == ADDR_ANALOG_MUX_OUTPUT);            // [RQ1]
  wire        is_status  = (fr_addr == ADDR_STATUS) && !fr_wr;  // [RQ6]
  wire        is_fault   = (fr_addr == ADDR_FAULT) && !fr_wr;   // [RQ17]
  wire        is_analog_mux_output    = (fr_addr == ADDR_ANALOG_MUX_OUTPUT);

  assign nxt_reply_kind = is_status ? RPL_STATUS :
                          is_fault  ? RPL_FAULT  :
                          is_analog_mux_output   ? RPL_ANALOG_MUX_OUTPUT   : RPL_PLAIN;

  // ********************************
  // Faults and interrupt flag
  // ********************************
  wire [FLT_N-1:0] flt_rise    = flt_sync & ~flt_prev_ff;
  wire             fault_rd    = frame_done
                                 && (reply_kind_ff == RPL_FAULT);
  // A fault still present survives the clearing read
  wire [FLG_W-1:0] nxt_flags   = {flt_sync, 1'b0}
                                 | (flags_ff & ~{FLG_W{fault_rd}}); // [RQ11]
  wire             fault_sum   = |flags_ff;                          // [RQ9]
  wire             int_event   = (|(sw_sync ^ sw_prev_ff))
                                 | (|flt_rise);                      // [RQ15]
  wire             int_clr     = frame_done & reply_ff[INTF_BIT];
  wire             nxt_intflg  = int_event | (intflg_ff & ~int_clr); // [RQ16]

  // ********************************
  // Reply word
  // ********************************
  genvar k;
  generate
    for (k = 0; k < SW_N; k++)
    begin : g_mask
      assign sel_mask[k] = (analog_mux_output_ff[SEL_W-1:0] == SEL_W'(k + 1)); // [RQ2]
    end
  endgenerate

  wire [SW_N-1:0]    status_bits = sw_sync & ~sel_mask;         // [RQ3]
  wire [FRAME_W-1:0] rpl_base    = {8'h00, fault_sum, intflg_ff,
                                    22'h00_0000};               // [RQ12]
  wire [FRAME_W-1:0] rpl_status  = rpl_base
                                   | {10'h000, status_bits};    // [RQ8]
  wire [FRAME_W-1:0] rpl_analog_mux_output    = rpl_base | {25'h000_0000, analog_mux_output_ff};
  wire [FRAME_W-1:0] rpl_fault   = {8'h00, 1'b0, intflg_ff, 14'h0000,
                                    flags_ff};                  // [RQ17]
  wire [FRAME_W-1:0] nxt_reply   =
    (reply_kind_ff == RPL_STATUS) ? rpl_status :
    (reply_kind_ff == RPL_ANALOG_MUX_OUTPUT)   ? rpl_analog_mux_output   :
    (reply_kind_ff == RPL_FAULT)  ? rpl_fault  : rpl_base;

  // ********************************
  // Interrupt pin release timer
  // ********************************
  wire cs_fall   = cs_seen_ff & ~cs_sync;
  wire rel_done  = rel_run_ff && (rel_cnt_ff == REL_LAST);
  // Release lets the pin go high unless a fault is still standing
  wire nxt_pend  = int_event
                   | (rel_done ? fault_sum : int_pend_ff);       // [RQ14]

  // ********************************
  // System domain registers
  // ********************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sw_prev_ff   <= 22'h00_0000;
      flt_prev_ff  <= 7'h00;
      cs_seen_ff   <= 1'b0;
      done_seen_ff <= 1'b0;
    end
    else
    begin
      sw_prev_ff   <= sw_sync;
      flt_prev_ff  <= flt_sync;
      cs_seen_ff   <= cs_sync;
      done_seen_ff <= done_sync;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      analog_mux_output_ff <= ANALOG_MUX_OUTPUT_RST;                                     // [RQ5]
    else if (analog_mux_output_wr)
      analog_mux_output_ff <= fr_data[ANALOG_MUX_OUTPUT_W-1:0];                          // [RQ1]
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reply_kind_ff <= RPL_PLAIN;
    else if (frame_done)
      reply_kind_ff <= nxt_reply_kind;                         // [RQ6]
  end

  // Reply is frozen while chip select is low so the link samples it clean
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reply_ff <= 32'h0000_0000;
    else if (cs_sync)
      reply_ff <= nxt_reply;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flags_ff  <= FLG_RST;                                    // [RQ10]
      intflg_ff <= 1'b1;                                       // [RQ10]
    end
    else
    begin
      flags_ff  <= nxt_flags;
      intflg_ff <= nxt_intflg;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rel_run_ff <= 1'b0;
      rel_cnt_ff <= 18'h0_0000;
    end
    else if (cs_fall)
    begin
      rel_run_ff <= 1'b1;                                      // [RQ14]
      rel_cnt_ff <= 18'h0_0000;
    end
    else if (rel_run_ff)
    begin
      rel_run_ff <= !rel_done;
      rel_cnt_ff <= rel_cnt_ff + 18'h0_0001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      int_pend_ff <= 1'b1;
      int_n_ff    <= 1'b0;
    end
    else
    begin
      int_pend_ff <= nxt_pend;
      int_n_ff    <= ~int_pend_ff;
    end
  end

  assign analog_channel_sel_out        = analog_mux_output_ff[SEL_W-1:0];  // [RQ2]
  assign analog_source_current_sel_out = analog_mux_output_ff[CUR_BIT];    // [RQ4]
  assign int_n_out                     = int_n_ff;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  analog_mux_output_write_a: assert property ( // [RQ1]
    analog_mux_output_wr |=> analog_channel_sel_out == $past(fr_data[5:0])
               && analog_source_current_sel_out == $past(fr_data[6]))
    else $error("analog select write not taken");
  analog_mux_output_hold_a: assert property ( // [RQ5]
    !analog_mux_output_wr |=> $stable(analog_mux_output_ff))
    else $error("analog select changed without a write");
  sel_mask_a: assert property ( // [RQ3]
    cs_sync && reply_kind_ff == RPL_STATUS
    |=> (reply_ff[21:0] & $past(sel_mask)) == 22'h00_0000)
    else $error("selected input not zero in status reply");
  status_map_a: assert property ( // [RQ8]
    cs_sync && reply_kind_ff == RPL_STATUS && analog_mux_output_ff[5:0] == CH_NONE
    |=> reply_ff[21:0] == $past(sw_sync))
    else $error("status reply bits do not match switches");
  fault_bit_a: assert property ( // [RQ9]
    cs_sync && reply_kind_ff != RPL_FAULT
    |=> reply_ff[FAULT_BIT] == $past(|flags_ff)
        && reply_ff[INTF_BIT] == $past(intflg_ff))
    else $error("fault or interrupt bit wrong in reply");
  fault_hold_a: assert property ( // [RQ11]
    fault_sum && !fault_rd |=> fault_sum)
    else $error("fault summary dropped without fault read");
  int_set_a: assert property ( // [RQ15]
    int_event |=> intflg_ff ##1 !int_n_out)
    else $error("interrupt event not flagged");
  int_clear_a: assert property ( // [RQ16]
    int_clr && !int_event |=> !intflg_ff)
    else $error("interrupt flag not cleared by reply");
  int_release_a: assert property ( // [RQ14]
    rel_done && fault_sum |-> ##2 !int_n_out)
    else $error("interrupt pin released with fault standing");
  rel_time_a: assert property ( // [RQ14]
    rel_done && !fault_sum && !int_event |-> ##2 int_n_out)
    else $error("interrupt pin not released on time");
  status_rd_c: cover property (frame_done && is_status);
  analog_mux_output_wr_c:   cover property (analog_mux_output_wr);
  fault_rd_c:  cover property (fault_rd);
  int_rel_c:   cover property (rel_done && !fault_sum);

endmodule

// file: tb/ssa_host_model.sv
// Host model: the serial master that faces the register block.
// Assumes the block samples data on link clock rise, shifts on fall.
`timescale 1ns/1ps
module ssa_host_model
  import ssa_pkg::*;
(
  // Serial link
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  localparam realtime HALF = 15.0;

  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b0;
    mosi_out = 1'b0;
    // A real rising edge idles the shifter before the first frame
    #1;
    cs_n_out = 1'b1;
  end

  // ********************************
  // One frame, MSB first
  // ********************************
  task automatic xfer(input  logic [FRAME_W-1:0] cmd,
                      output logic [FRAME_W-1:0] rsp);
    int k;
    // Odd offset keeps link edges off the system clock edges
    #3.7;
    cs_n_out = 1'b0;
    #HALF;
    for (k = FRAME_W - 1; k >= 0; k--)
    begin
      mosi_out = cmd[k];
      #HALF;
      sclk_out = 1'b1;
      rsp[k]   = miso_in;
      #HALF;
      sclk_out = 1'b0;
    end
    #HALF;
    cs_n_out = 1'b1;
    // Released line shows no stale value
    mosi_out = ~mosi_out;
    // Gap leaves room for decode before the next frame
    #(4 * HALF);
  endtask
endmodule

// file: tb/tb.sv
// Testbench for the switch status and analog select register block.
// Assumes the host model as serial master and a short interrupt timer.
`timescale 1ns/1ps
module tb
  import ssa_pkg::*;
;
  localparam int REL_CYC = 50;
  localparam int LIMIT   = 40000;

  logic              sys_clk;
  logic              rst_n;
  logic              sclk;
  logic              cs_n;
  logic              mosi;
  logic              miso;
  logic [SG_N-1:0]   sg;
  logic [SP_N-1:0]   sp;
  logic [FLT_N-1:0]  flt;
  logic [SEL_W-1:0]  sel;
  logic              cur;
  logic              int_n;
  logic [31:0]       rsp;
  logic [31:0]       t;
  int                num_errors;
  int                check_count;
  int                cycles;
  int                c;

  ssa_regs #(.INT_REL_CYC(REL_CYC)) i_ssa_regs (
    .sys_clk_in                    (sys_clk),
    .rst_n_in                      (rst_n),
    .sclk_in                       (sclk),
    .cs_n_in                       (cs_n),
    .mosi_in                       (mosi),
    .miso_out                      (miso),
    .ground_switch_input_in        (sg),
    .programmable_switch_input_in  (sp),
    .fault_cond_in                 (flt),
    .analog_channel_sel_out        (sel),
    .analog_source_current_sel_out (cur),
    .int_n_out                     (int_n)
  );

  ssa_host_model i_ssa_host_model (
    .sclk_out (sclk),
    .cs_n_out (cs_n),
    .mosi_out (mosi),
    .miso_in  (miso)
  );

  // ********************************
  // Clock and hang guard
  // ********************************
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    cycles = 0;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      num_errors++;
      complete_run();
    end
  end

  // ********************************
  // Helpers
  // ********************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic send(input logic [6:0] a, input logic w,
                      input logic [23:0] d);
    i_ssa_host_model.xfer({a, w, d}, rsp);
  endtask

  task automatic cmp_rsp(input string what, input logic [31:0] mask,
                         input logic [31:0] exp);
    check_count++;
    if ((rsp & mask) !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, rsp & mask);
    end
  endtask

  task automatic cmp_val(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Selected input reads open in the status word
  function automatic logic [31:0] stat_exp(input logic f, input logic i,
                                           input int ch);
    logic [21:0] sw;
    sw = {sp, sg};
    if (ch >= 1 && ch <= 22)
      sw[ch-1] = 1'b0;
    return {8'h00, f, i, sw};
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial
  begin
    sg = '0;
    sp = '0;
    flt = '0;
    rst_n = 1'b0;
    num_errors = 0;
    check_count = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(2);
    cmp_val("channel select", 24'(CH_NONE), 24'(sel));
    cmp_val("current select", 24'h0, 24'(cur));
    cmp_val("interrupt pin", 24'h0, 24'(int_n));
    cmp_val("idle reply line", 24'h0, 24'(miso));
    @(posedge sys_clk);
    sg <= 14'h3b7f;
    sp <= 8'hde;
    tick(10);
    send(ADDR_STATUS, 1'b0, 24'h0);
    cmp_rsp("power-on flags", 32'hffc00000, 32'h00c00000);
    send(ADDR_STATUS, 1'b0, 24'h0);
    cmp_rsp("status word", 32'hffbfffff, stat_exp(1'b1, 1'b0, 0));
    $display("test reset and status done");

    // Every channel code, ending back on none
    for (c = 24; c >= 0; c--)
    begin
      send(ADDR_ANALOG_MUX_OUTPUT, 1'b1, {17'h0, c[0], 6'(c)});
      cmp_val("channel select", 24'(c), 24'(sel));
      cmp_val("current select", 24'(c[0]), 24'(cur));
      send(ADDR_STATUS, 1'b0, 24'h0);
      cmp_rsp("analog register", 32'hffbfffff,
              {8'h00, 1'b1, 16'h0, c[0], 6'(c)});
      send(ADDR_ANALOG_MUX_OUTPUT, 1'b0, 24'h0);
      cmp_rsp("status with selection", 32'hffffffff,
              stat_exp(1'b1, 1'b0, c));
    end
    cmp_val("interrupt held", 24'h0, 24'(int_n));
    $display("test analog select done");

    send(ADDR_FAULT, 1'b0, 24'h0);
    send(ADDR_STATUS, 1'b0, 24'h0);
    cmp_rsp("power-on fault flags", 32'hffffffff, 32'h00000001);
    send(ADDR_STATUS, 1'b0, 24'h0);
    cmp_rsp("status after clear", 32'hffffffff,
            stat_exp(1'b0, 1'b0, 0));
    cmp_val("interrupt released", 24'h1, 24'(int_n));
    $display("test fault clear done");

    // Fault that stays present
    @(posedge sys_clk);
    flt <= 7'h04;
    tick(10);
    cmp_val("interrupt on fault", 24'h0, 24'(int_n));
    send(ADDR_STATUS, 1'b0, 24'h0);
    t = rsp;
    send(ADDR_FAULT, 1'b0, 24'h0);
    cmp_val("fault event flag", 24'h1, 24'(t[22] | rsp[22]));
    cmp_rsp("fault summary", 32'h00800000, 32'h00800000);
    send(ADDR_STATUS, 1'b0, 24'h0);
    cmp_rsp("lasting fault flags", 32'hffbfffff, 32'h00000008);
    send(ADDR_STATUS, 1'b0, 24'h0);
    cmp_rsp("flag not raised again", 32'hffffffff,
            stat_exp(1'b1, 1'b0, 0));
    $display("test lasting fault done");

    // Switch change, then an unmapped address
    @(posedge sys_clk);
    sg <= 14'h3b7e;
    tick(10);
    send(ADDR_STATUS, 1'b0, 24'h0);
    t = rsp;
    send(ADDR_STATUS, 1'b0, 24'h0);
    cmp_val("switch event flag", 24'h1, 24'(t[22] | rsp[22]));
    cmp_rsp("changed switches", 32'hffffffff,
            stat_exp(1'b1, 1'b0, 0));
    send(7'h7f, 1'b0, 24'h0);
    send(ADDR_STATUS, 1'b0, 24'h0);
    cmp_rsp("plain reply", 32'hffbfffff, 32'h00800000);
    $display("test switch change done");
    complete_run();
  end
endmodule
